// ===== src/pwc_pkg.sv
package pwc_pkg;

  localparam int unsigned PWC_CHANNELS     = 6;
  localparam int unsigned PWC_ADDR_W       = 4;
  localparam int unsigned PWC_DATA_W       = 8;
  localparam int unsigned PWC_CODE_W       = 3;
  localparam int unsigned PWC_DIV_W        = 7;

  localparam logic [3:0] PWC_OFS_ENABLE        = 4'h0;
  localparam logic [3:0] PWC_OFS_START_LEVEL   = 4'h1;
  localparam logic [3:0] PWC_OFS_CLOCK_CHOICE  = 4'h2;
  localparam logic [3:0] PWC_OFS_PRESCALE      = 4'h3;
  localparam logic [3:0] PWC_OFS_ALIGNMENT     = 4'h4;
  localparam logic [3:0] PWC_OFS_JOIN          = 4'h5;
  localparam logic [3:0] PWC_OFS_SCALE_A       = 4'h6;
  localparam logic [3:0] PWC_OFS_SCALE_B       = 4'h7;
  localparam logic [3:0] PWC_OFS_STATUS        = 4'h8;

  localparam int unsigned PWC_PRE_A_LSB    = 0;
  localparam int unsigned PWC_PRE_B_LSB    = 4;
  localparam int unsigned PWC_JOIN_LOW_BIT = 4;
  localparam int unsigned PWC_JOIN_MID_BIT = 5;
  localparam int unsigned PWC_JOIN_UP_BIT  = 6;

  localparam logic [7:0] PWC_RST_CFG      = 8'h00;
  localparam logic [7:0] PWC_RST_SCALE    = 8'h00;
  localparam logic [5:0] PWC_GROUP_A_MASK = 6'h33;

  typedef struct packed {
    logic [5:0] start_level;
    logic [5:0] clock_choice;
    logic [2:0] clock_a_divide_code;
    logic [2:0] clock_b_divide_code;
    logic [5:0] center_align;
    logic [5:0] channel_enable;
    logic [2:0] join_pair;
    logic [7:0] clock_a_scale_value;
    logic [7:0] clock_b_scale_value;
  } pwc_cfg_t;

  typedef struct packed {
    logic [5:0] start_level;
    logic [5:0] use_scaled;
    logic [5:0] center_align;
    logic [5:0] active;
    logic [5:0] tick;
  } pwc_chan_t;

  typedef enum logic [1:0] {
    PWC_IDLE,
    PWC_ARMED,
    PWC_RUN
  } pwc_en_state_t;

endpackage : pwc_pkg

// ===== src/pwc_prescaler.sv
`timescale 1ns/10ps
module pwc_prescaler
  import pwc_pkg::*;
#(
  parameter int unsigned CODE_W = PWC_CODE_W,
  parameter int unsigned DIV_W  = PWC_DIV_W
) (
  input  wire logic              clock,
  input  wire logic              rst_n,
  input  wire logic              run,
  input  wire logic [CODE_W-1:0] code,
  input  wire logic [7:0]        scale,
  output logic                   tick,
  output logic                   scaled_tick
);

  logic [DIV_W-1:0] count;
  logic [DIV_W-1:0] next_count;
  logic [7:0]       scount;
  logic [7:0]       next_scount;
  logic             half;
  logic             next_half;
  logic             next_tick;
  logic             next_scaled_tick;
  logic [DIV_W-1:0] mask;

  // Power-of-two divider then scale-and-halve divider
  always_comb begin
    mask             = DIV_W'((1 << code) - 1);
    next_count       = run ? DIV_W'(count + 1'b1) : '0;
    next_tick        = run && ((count & mask) == mask);
    next_scount      = scount;
    next_half        = half;
    next_scaled_tick = 1'b0;
    if (!run) begin
      next_scount = '0;
      next_half   = 1'b0;
    end else if (next_tick) begin
      // Scale value zero counts as 256
      if (scount == 8'(scale - 8'h01)) begin
        next_scount      = '0;
        next_half        = !half;
        next_scaled_tick = half;
      end else begin
        next_scount = 8'(scount + 8'h01);
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      count       <= '0;
      scount      <= '0;
      half        <= 1'b0;
      tick        <= 1'b0;
      scaled_tick <= 1'b0;
    end else begin
      count       <= next_count;
      scount      <= next_scount;
      half        <= next_half;
      tick        <= next_tick;
      scaled_tick <= next_scaled_tick;
    end
  end

endmodule : pwc_prescaler

// ===== src/pwc_channel.sv
`timescale 1ns/10ps
module pwc_channel
  import pwc_pkg::*;
(
  input  wire logic       clock,
  input  wire logic       rst_n,
  input  wire logic       tick,
  input  wire logic       active,
  input  wire logic       start_level,
  input  wire logic       center_align,
  input  wire logic [7:0] period,
  input  wire logic [7:0] duty,
  output logic            wave
);

  logic [7:0] count;
  logic [7:0] next_count;
  logic       down;
  logic       next_down;
  logic       next_wave;
  logic       in_duty;

  // Counter: up only, or up then down
  always_comb begin
    next_count = count;
    next_down  = down;
    if (!active) begin
      next_count = '0;
      next_down  = 1'b0;
    end else if (tick) begin
      if (!center_align) begin
        next_down  = 1'b0;
        next_count = (count >= 8'(period - 8'h01)) ? 8'h00 : 8'(count + 8'h01);
      end else if (!down) begin
        if (count >= 8'(period - 8'h01)) begin
          next_down = 1'b1;
        end else begin
          next_count = 8'(count + 8'h01);
        end
      end else if (count == 8'h00) begin
        next_down = 1'b0;
      end else begin
        next_count = 8'(count - 8'h01);
      end
    end
    in_duty = (next_count < duty);
    next_wave = active ? (in_duty ? start_level : !start_level) : start_level;
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      count <= '0;
      down  <= 1'b0;
      wave  <= 1'b0;
    end else begin
      count <= next_count;
      down  <= next_down;
      wave  <= next_wave;
    end
  end

endmodule : pwc_channel

// ===== src/pwc_top.sv
// The register offsets and the strobed register port were chosen for this implementation.
`timescale 1ns/10ps
// Function
// - Start level 1: output high at period start, low after duty.
// - Start level 0: output low at period start, high after duty.
// - Start level writes always taken; one odd pulse may result.
// - Channels 0,1,4,5 use clock A when bit 0, SA when 1.
// - Channels 2,3 use clock B when bit 0, SB when 1.
// - Clock choice writes always taken; one odd pulse may result.
// - Clock A is bus clock divided by two to code power.
// - Clock B divided likewise by its own independent code.
// - A and SA feed only 0,1,4,5; B and SB only 2,3.
// - Prescale codes writable anytime; one odd pulse may result.
// - Alignment bit 1 gives center aligned, 0 left aligned.
// - All four config registers readable and writable anytime.
// - Six bits per register; bit x controls channel x.
// - Joined pair takes clock, polarity, alignment from low-order channel.
// - SA is clock A divided by scale value, then by two.
// - Enabled channel starts at next cycle of its clock source.
module pwc_top
  import pwc_pkg::*;
#(
  parameter int unsigned CHANNELS = PWC_CHANNELS
) (
  input  wire logic                  clock,
  input  wire logic                  rst_n,
  input  wire logic [PWC_ADDR_W-1:0] addr,
  input  wire logic [PWC_DATA_W-1:0] wdata,
  input  wire logic                  wr_stb,
  input  wire logic                  rd_stb,
  input  wire logic [8*CHANNELS-1:0] period_flat,
  input  wire logic [8*CHANNELS-1:0] duty_flat,
  output logic [PWC_DATA_W-1:0]      rdata,
  output logic [CHANNELS-1:0]        wave_out,
  output pwc_chan_t                  chan_cfg
);

  pwc_cfg_t          cfg;
  pwc_cfg_t          next_cfg;
  logic [7:0]        next_rdata;
  pwc_en_state_t     en_state [CHANNELS];
  pwc_en_state_t     next_en_state [CHANNELS];
  logic [5:0]        owner;
  logic [5:0]        src_tick;
  logic [5:0]        ch_wave;
  logic [5:0]        raw_wave;
  logic              tick_a;
  logic              tick_sa;
  logic              tick_b;
  logic              tick_sb;
  logic              any_enabled;
  pwc_chan_t         next_chan;

  function automatic logic [7:0] pad6(input logic [5:0] v);
    pad6 = {2'b00, v};
  endfunction : pad6

  // Register writes, no mode restriction
  always_comb begin
    next_cfg = cfg;
    if (wr_stb) begin
      if (addr == PWC_OFS_ENABLE) begin
        next_cfg.channel_enable = wdata[5:0];
      end else if (addr == PWC_OFS_START_LEVEL) begin
        next_cfg.start_level = wdata[5:0];
      end else if (addr == PWC_OFS_CLOCK_CHOICE) begin
        next_cfg.clock_choice = wdata[5:0];
      end else if (addr == PWC_OFS_PRESCALE) begin
        next_cfg.clock_a_divide_code = wdata[PWC_PRE_A_LSB +: 3];
        next_cfg.clock_b_divide_code = wdata[PWC_PRE_B_LSB +: 3];
      end else if (addr == PWC_OFS_ALIGNMENT) begin
        next_cfg.center_align = wdata[5:0];
      end else if (addr == PWC_OFS_JOIN) begin
        next_cfg.join_pair = {wdata[PWC_JOIN_UP_BIT], wdata[PWC_JOIN_MID_BIT], wdata[PWC_JOIN_LOW_BIT]};
      end else if (addr == PWC_OFS_SCALE_A) begin
        next_cfg.clock_a_scale_value = wdata;
      end else if (addr == PWC_OFS_SCALE_B) begin
        next_cfg.clock_b_scale_value = wdata;
      end
    end
  end

  // Read path, answer in the following cycle
  always_comb begin
    next_rdata = 8'h00;
    if (rd_stb) begin
      if (addr == PWC_OFS_ENABLE) begin
        next_rdata = pad6(cfg.channel_enable);
      end else if (addr == PWC_OFS_START_LEVEL) begin
        next_rdata = pad6(cfg.start_level);
      end else if (addr == PWC_OFS_CLOCK_CHOICE) begin
        next_rdata = pad6(cfg.clock_choice);
      end else if (addr == PWC_OFS_PRESCALE) begin
        next_rdata = {1'b0, cfg.clock_b_divide_code, 1'b0, cfg.clock_a_divide_code};
      end else if (addr == PWC_OFS_ALIGNMENT) begin
        next_rdata = pad6(cfg.center_align);
      end else if (addr == PWC_OFS_JOIN) begin
        next_rdata = {1'b0, cfg.join_pair, 4'h0};
      end else if (addr == PWC_OFS_SCALE_A) begin
        next_rdata = cfg.clock_a_scale_value;
      end else if (addr == PWC_OFS_SCALE_B) begin
        next_rdata = cfg.clock_b_scale_value;
      end else if (addr == PWC_OFS_STATUS) begin
        next_rdata = pad6(ch_wave);
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      cfg   <= '0;
      rdata <= 8'h00;
    end else begin
      cfg   <= next_cfg;
      rdata <= next_rdata;
    end
  end

  assign any_enabled = |cfg.channel_enable;

  pwc_prescaler u_pre_a (
    .clock       (clock),
    .rst_n       (rst_n),
    .run         (any_enabled),
    .code        (cfg.clock_a_divide_code),
    .scale       (cfg.clock_a_scale_value),
    .tick        (tick_a),
    .scaled_tick (tick_sa)
  );

  pwc_prescaler u_pre_b (
    .clock       (clock),
    .rst_n       (rst_n),
    .run         (any_enabled),
    .code        (cfg.clock_b_divide_code),
    .scale       (cfg.clock_b_scale_value),
    .tick        (tick_b),
    .scaled_tick (tick_sb)
  );

  // Control bits owner per channel; joined pair uses low-order channel
  always_comb begin
    for (int i = 0; i < 6; i++) begin
      owner[i] = 1'b0;
    end
    for (int i = 0; i < 6; i++) begin
      next_chan.start_level[i]  = 1'b0;
      next_chan.use_scaled[i]   = 1'b0;
      next_chan.center_align[i] = 1'b0;
      next_chan.active[i]       = 1'b0;
      next_chan.tick[i]         = 1'b0;
    end
    for (int i = 0; i < 6; i++) begin
      owner[i] = (i % 2 == 0) && cfg.join_pair[i/2];
      next_chan.start_level[i]  = cfg.start_level[owner[i] ? i + 1 : i];
      next_chan.use_scaled[i]   = cfg.clock_choice[owner[i] ? i + 1 : i];
      next_chan.center_align[i] = cfg.center_align[owner[i] ? i + 1 : i];
      next_chan.active[i]       = (en_state[i] == PWC_RUN);
      if (PWC_GROUP_A_MASK[i]) begin
        src_tick[i] = next_chan.use_scaled[i] ? tick_sa : tick_a;
      end else begin
        src_tick[i] = next_chan.use_scaled[i] ? tick_sb : tick_b;
      end
      next_chan.tick[i] = src_tick[i];
    end
  end

  always_comb begin
    for (int i = 0; i < CHANNELS; i++) begin
      next_en_state[i] = en_state[i];
      case (en_state[i])
        PWC_IDLE: begin
          if (cfg.channel_enable[i] && !owner[i]) begin
            next_en_state[i] = PWC_ARMED;
          end
        end
        PWC_ARMED: begin
          if (!cfg.channel_enable[i] || owner[i]) begin
            next_en_state[i] = PWC_IDLE;
          end else if (src_tick[i]) begin
            next_en_state[i] = PWC_RUN;
          end
        end
        default: begin
          if (!cfg.channel_enable[i] || owner[i]) begin
            next_en_state[i] = PWC_IDLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clock) begin
    for (int i = 0; i < CHANNELS; i++) begin
      if (!rst_n) begin
        en_state[i] <= PWC_IDLE;
      end else begin
        en_state[i] <= next_en_state[i];
      end
    end
  end

  genvar g;
  generate
    for (g = 0; g < 6; g++) begin : g_ch
      pwc_channel u_ch (
        .clock        (clock),
        .rst_n        (rst_n),
        .tick         (src_tick[g]),
        .active       (en_state[g] == PWC_RUN),
        .start_level  (next_chan.start_level[g]),
        .center_align (next_chan.center_align[g]),
        .period       (period_flat[8*g +: 8]),
        .duty         (duty_flat[8*g +: 8]),
        .wave         (raw_wave[g])
      );
    end
  endgenerate

  always_comb begin
    for (int i = 0; i < 6; i++) begin
      ch_wave[i] = raw_wave[i];
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      wave_out <= '0;
      chan_cfg <= '0;
    end else begin
      wave_out <= ch_wave & ~owner;
      chan_cfg <= next_chan;
    end
  end

  // Write then read of the start level register
  sequence s_level_write;
    wr_stb && addr == PWC_OFS_START_LEVEL;
  endsequence : s_level_write

  sequence s_level_read;
    rd_stb && addr == PWC_OFS_START_LEVEL;
  endsequence : s_level_read

  // Channel 3 idle for two cycles
  sequence s_ch3_idle_twice;
    en_state[3] == PWC_IDLE ##1 en_state[3] == PWC_IDLE;
  endsequence : s_ch3_idle_twice

  // Clock A running undivided for two cycles
  sequence s_a_undivided_twice;
    any_enabled && cfg.clock_a_divide_code == 3'h0 ##1 any_enabled && cfg.clock_a_divide_code == 3'h0;
  endsequence : s_a_undivided_twice

  a_cfg_readback: assert property (@(posedge clock) disable iff (!rst_n)
    s_level_write ##1 s_level_read
    |=> rdata == {2'b00, $past(wdata[5:0], 2)})
    else $error("start level readback mismatch");

  a_reset_zero: assert property (@(posedge clock)
    !rst_n |=> cfg == '0 && rdata == 8'h00)
    else $error("configuration not zero after reset");

  a_enable_wait: assert property (@(posedge clock) disable iff (!rst_n)
    en_state[0] == PWC_ARMED && !src_tick[0] && cfg.channel_enable[0] && !owner[0]
    |=> en_state[0] == PWC_ARMED)
    else $error("channel started before source tick");

  a_group_a: assert property (@(posedge clock) disable iff (!rst_n)
    src_tick[1] == (cfg.clock_choice[1] ? tick_sa : tick_a))
    else $error("channel 1 clock routing wrong");

  a_group_b: assert property (@(posedge clock) disable iff (!rst_n)
    !cfg.join_pair[1] |-> src_tick[2] == (cfg.clock_choice[2] ? tick_sb : tick_b))
    else $error("channel 2 clock routing wrong");

  a_group_b_ch3: assert property (@(posedge clock) disable iff (!rst_n)
    src_tick[3] == (cfg.clock_choice[3] ? tick_sb : tick_b))
    else $error("channel 3 clock routing wrong");

  a_join_owner: assert property (@(posedge clock) disable iff (!rst_n)
    cfg.join_pair[0] |=> chan_cfg.start_level[0] == $past(cfg.start_level[1]))
    else $error("joined pair polarity not from low-order channel");

  // upper channel of joined pair parked
  a_join_idle: assert property (@(posedge clock) disable iff (!rst_n)
    cfg.join_pair[0] |=> en_state[0] == PWC_IDLE)
    else $error("joined pair upper channel still running");

  // upper output of joined pair off
  a_join_mask: assert property (@(posedge clock) disable iff (!rst_n)
    cfg.join_pair[1] |=> !wave_out[2])
    else $error("joined pair upper output not off");

  a_idle_level: assert property (@(posedge clock) disable iff (!rst_n)
    s_ch3_idle_twice |=> ch_wave[3] == $past(next_chan.start_level[3]))
    else $error("idle output not at start level");

  a_align_pass: assert property (@(posedge clock) disable iff (!rst_n)
    !cfg.join_pair[2] |=> chan_cfg.center_align[5] == $past(cfg.center_align[5]))
    else $error("channel 5 alignment not passed on");

  a_rdata_idle: assert property (@(posedge clock) disable iff (!rst_n)
    !rd_stb |=> rdata == 8'h00)
    else $error("read data not zero outside read cycle");

  // undivided clock A ticks every cycle
  a_clock_a_full: assert property (@(posedge clock) disable iff (!rst_n)
    s_a_undivided_twice |=> tick_a)
    else $error("undivided clock A missing tick");

  a_prescale_idle: assert property (@(posedge clock) disable iff (!rst_n)
    !any_enabled |=> !tick_a && !tick_b)
    else $error("prescaler ticking with all channels disabled");

  // scaled tick only on a clock A tick
  a_scaled_on_tick: assert property (@(posedge clock) disable iff (!rst_n)
    tick_sa |-> tick_a)
    else $error("scaled clock A tick without clock A tick");

endmodule : pwc_top

// ===== test/test_pwc_top.sv
`timescale 1ns/10ps
module test_pwc_top;
  import pwc_pkg::*;

  logic                  clock;
  logic                  rst_n;
  logic [PWC_ADDR_W-1:0] addr;
  logic [PWC_DATA_W-1:0] wdata;
  logic                  wr_stb;
  logic                  rd_stb;
  logic [47:0]           period_flat;
  logic [47:0]           duty_flat;
  logic [PWC_DATA_W-1:0] rdata;
  logic [5:0]            wave_out;
  pwc_chan_t             chan_cfg;
  int                    err_total;
  int                    n_tests;
  int                    ticks [6];
  int                    highs [6];
  int                    rises [6];

  pwc_top dut (
    .clock       (clock),
    .rst_n       (rst_n),
    .addr        (addr),
    .wdata       (wdata),
    .wr_stb      (wr_stb),
    .rd_stb      (rd_stb),
    .period_flat (period_flat),
    .duty_flat   (duty_flat),
    .rdata       (rdata),
    .wave_out    (wave_out),
    .chan_cfg    (chan_cfg)
  );

  task end_sim;
    if (err_total == 0 && n_tests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : end_sim

  task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value %s expected %0h seen %0h", name, exp, got);
    end
  endtask : chk

  task wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clock);
    addr   <= a;
    wdata  <= d;
    wr_stb <= 1'b1;
    @(posedge clock);
    wr_stb <= 1'b0;
  endtask : wr

  task rd(input logic [3:0] a, input logic [7:0] exp);
    @(posedge clock);
    addr   <= a;
    rd_stb <= 1'b1;
    @(posedge clock);
    rd_stb <= 1'b0;
    #1;
    chk("rdata", {24'h000000, exp}, {24'h000000, rdata});
  endtask : rd

  // Settle, then count ticks, high cycles and rising edges per channel
  task measure;
    logic [5:0] prev;
    for (int g = 0; g < 6; g++) begin
      ticks[g] = 0;
      highs[g] = 0;
      rises[g] = 0;
    end
    repeat (256) @(negedge clock);
    prev = wave_out;
    repeat (768) begin
      @(negedge clock);
      for (int g = 0; g < 6; g++) begin
        ticks[g] += int'(chan_cfg.tick[g] === 1'b1);
        highs[g] += int'(wave_out[g] === 1'b1);
        rises[g] += int'(wave_out[g] === 1'b1 && prev[g] === 1'b0);
      end
      prev = wave_out;
    end
  endtask : measure

  task t_reset;
    for (int a = 1; a < 5; a++) begin
      rd(4'(a), 8'h00);
    end
    @(posedge clock);
    #1;
    chk("rdata idle", 32'h0, {24'h0, rdata});
    chk("chan_cfg", 32'h0, 32'(chan_cfg));
  endtask : t_reset

  task t_regs;
    wr(4'h1, 8'hD5);
    wr(4'h2, 8'h6A);
    wr(4'h4, 8'hF3);
    wr(4'h3, 8'hFF);
    wr(4'hF, 8'hFF);
    rd(4'h1, 8'h15);
    rd(4'h2, 8'h2A);
    rd(4'h4, 8'h33);
    rd(4'h3, 8'h77);
    rd(4'hF, 8'h00);
    rd(4'h9, 8'h00);
    chk("start_level", 32'h15, {26'h0, chan_cfg.start_level});
    chk("use_scaled", 32'h2A, {26'h0, chan_cfg.use_scaled});
    chk("center_align", 32'h33, {26'h0, chan_cfg.center_align});
    // Write and read with no gap
    @(posedge clock);
    addr   <= PWC_OFS_START_LEVEL;
    wdata  <= 8'h2C;
    wr_stb <= 1'b1;
    @(posedge clock);
    wr_stb <= 1'b0;
    rd_stb <= 1'b1;
    @(posedge clock);
    rd_stb <= 1'b0;
    #1;
    chk("back to back rdata", 32'h2C, {24'h0, rdata});
    wr(4'h1, 8'h00);
    wr(4'h2, 8'h00);
    wr(4'h4, 8'h00);
  endtask : t_regs

  // Group A channels follow code n, group B the mirrored code
  task t_prescale;
    int exp;
    wr(4'h0, 8'h3F);
    for (int n = 0; n < 8; n++) begin
      wr(4'h3, {1'b0, 3'(7 - n), 1'b0, 3'(n)});
      measure();
      for (int g = 0; g < 6; g++) begin
        exp = (g == 2 || g == 3) ? (768 >> (7 - n)) : (768 >> n);
        chk("tick", exp, ticks[g]);
      end
    end
  endtask : t_prescale

  task t_scaled;
    wr(4'h3, 8'h10);
    wr(4'h6, 8'h02);
    wr(4'h7, 8'h03);
    rd(4'h6, 8'h02);
    rd(4'h7, 8'h03);
    wr(4'h2, 8'h3F);
    measure();
    for (int g = 0; g < 6; g++) begin
      chk("scaled tick", (g == 2 || g == 3) ? 64 : 192, ticks[g]);
    end
    wr(4'h2, 8'h00);
    wr(4'h3, 8'h00);
  endtask : t_scaled

  // Period 4, duty 1, undivided clock on every channel
  task t_wave(input logic [5:0] lvl, input logic [5:0] algn);
    wr(4'h0, 8'h00);
    wr(4'h4, {2'b00, algn});
    wr(4'h0, 8'h3F);
    wr(4'h1, {2'b00, lvl});
    measure();
    for (int g = 0; g < 6; g++) begin
      chk("high cycles", lvl[g] ? 192 : 576, highs[g]);
      chk("rising edges", algn[g] ? 96 : 192, rises[g]);
    end
    chk("active", 32'h3F, {26'h0, chan_cfg.active});
  endtask : t_wave

  // All three pairs joined; odd channels control, even outputs off
  task t_join;
    wr(4'h0, 8'h00);
    wr(4'h5, 8'h70);
    wr(4'h1, 8'h2A);
    wr(4'h0, 8'h3F);
    rd(4'h0, 8'h3F);
    rd(4'h5, 8'h70);
    measure();
    for (int g = 0; g < 6; g += 2) begin
      chk("joined upper wave", 32'h0, highs[g]);
    end
    chk("joined start level", 32'h3F, {26'h0, chan_cfg.start_level});
    chk("joined active", 32'h2A, {26'h0, chan_cfg.active});
    wr(4'h0, 8'h00);
    repeat (4) @(posedge clock);
    rd(4'h8, 8'h3F);
    wr(4'h5, 8'h00);
  endtask : t_join

  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  initial begin
    #240000;
    err_total++;
    end_sim();
  end

  initial begin
    err_total   = 0;
    n_tests     = 0;
    rst_n       = 1'b0;
    addr        = '0;
    wdata       = '0;
    wr_stb      = 1'b0;
    rd_stb      = 1'b0;
    period_flat = {6{8'h04}};
    duty_flat   = {6{8'h01}};
    repeat (3) @(posedge clock);
    rst_n <= 1'b1;
    t_reset();
    t_regs();
    t_prescale();
    t_scaled();
    t_wave(6'h15, 6'h00);
    t_wave(6'h2A, 6'h3F);
    t_wave(6'h0F, 6'h33);
    t_join();
    end_sim();
  end

endmodule : test_pwc_top
